// ### common/fifo_flags_pkg.sv
package fifo_flags_pkg;
  localparam int IDX_W = 5;
  localparam int CNT_W = 6;
  localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ONE   = 5'h01;
  localparam int FLAG_LOW  = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_EF   = 2;
  localparam int FLAG_W    = 3;
endpackage

// ### rtl/can_fifo_status_flags.sv
`timescale 1ns/1ps
module can_fifo_status_flags (
  // Clock and reset.
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  // Configuration.
  input  wire logic                               fifo_direction_select,
  input  wire logic [fifo_flags_pkg::IDX_W-1:0]   fifo_depth_setting,
  // Message engine events.
  input  wire logic                               msg_queued,
  input  wire logic                               msg_done,
  input  wire logic                               fifo_reset,
  input  wire logic                               transmit_queue_reset,
  input  wire logic                               send_request_bit,
  input  wire logic                               serial_write,
  input  wire logic                               sticky_event,
  // Software access.
  input  wire logic                               status_read,
  // Status out.
  output logic                                    empty_or_full_flag,
  output logic                                    half_level_flag,
  output logic                                    not_full_or_not_empty_flag,
  output logic      [fifo_flags_pkg::IDX_W-1:0]   current_message_index,
  output logic      [fifo_flags_pkg::CNT_W-1:0]   message_count,
  output logic                                    sticky_status
);
  typedef struct packed {
    logic [fifo_flags_pkg::CNT_W-1:0]  count;
    logic                              sticky;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;
  logic [fifo_flags_pkg::CNT_W-1:0] depth;
  logic [fifo_flags_pkg::CNT_W:0]   twice_count;
  logic                             is_full;
  logic                             is_empty;

  // Depth is the size setting plus one; the count is one bit wider than the index.
  assign depth       = {1'b0, fifo_depth_setting} + fifo_flags_pkg::CNT_ONE;
  assign twice_count = {state.count, 1'b0};
  assign is_full     = (state.count >= depth);
  assign is_empty    = (state.count == fifo_flags_pkg::CNT_RESET);

  // Occupancy: in transmit mode queue adds and completion drains, in receive mode
  // a received message fills and software draining is msg_done too; a full FIFO
  // ignores further fills rather than wrap.
  always_comb begin
    next_state = state;
    if (fifo_reset || transmit_queue_reset) begin
      next_state.count = fifo_flags_pkg::CNT_RESET;
    end else begin
      if (msg_queued && !msg_done && !is_full) begin
        next_state.count = state.count + fifo_flags_pkg::CNT_ONE;
      end else if (msg_done && !msg_queued && !is_empty) begin
        next_state.count = state.count - fifo_flags_pkg::CNT_ONE;
      end
    end
    // Set beats clear so an event in the clearing cycle is not lost.
    if (status_read || transmit_queue_reset || send_request_bit || serial_write) begin
      next_state.sticky = 1'b0;
    end
    if (sticky_event) begin
      next_state.sticky = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state.count  <= fifo_flags_pkg::CNT_RESET;
      state.sticky <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Flags follow the registered count directly, so they change with it.
  always_comb begin
    if (fifo_direction_select) begin
      empty_or_full_flag         = is_empty;
      half_level_flag            = ({1'b0, depth} >= twice_count);
      not_full_or_not_empty_flag = !is_full;
    end else begin
      empty_or_full_flag         = is_full;
      half_level_flag            = (twice_count >= {1'b0, depth});
      not_full_or_not_empty_flag = !is_empty;
    end
  end

  assign message_count = state.count;
  assign sticky_status = state.sticky;

  // Index tracking lives in its own small module.
  fifo_index_tracker u_index (
    .clk_sys               (clk_sys),
    .rstn                  (rstn),
    .fifo_reset            (fifo_reset | transmit_queue_reset),
    .msg_done              (msg_done),
    .fifo_depth_setting    (fifo_depth_setting),
    .current_message_index (current_message_index)
  );
endmodule

// ### rtl/fifo_index_tracker.sv
`timescale 1ns/1ps
module fifo_index_tracker (
  // Clock and reset.
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  // Events and the size setting.
  input  wire logic                               fifo_reset,
  input  wire logic                               msg_done,
  input  wire logic [fifo_flags_pkg::IDX_W-1:0]   fifo_depth_setting,
  // Index out.
  output logic      [fifo_flags_pkg::IDX_W-1:0]   current_message_index
);
  typedef struct packed {
    logic [fifo_flags_pkg::IDX_W-1:0] idx;
  } idx_state_t;

  idx_state_t state;
  idx_state_t next_state;

  // Index moves only on a completed or aborted message or a FIFO reset (back to zero), wrapping at the size setting.
  always_comb begin
    next_state = state;
    if (fifo_reset) begin
      next_state.idx = fifo_flags_pkg::IDX_RESET;
    end else if (msg_done) begin
      if (state.idx >= fifo_depth_setting) begin
        next_state.idx = fifo_flags_pkg::IDX_RESET;
      end else begin
        next_state.idx = state.idx + fifo_flags_pkg::IDX_ONE;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state.idx <= fifo_flags_pkg::IDX_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign current_message_index = state.idx;
endmodule

// ### sim/can_fifo_status_flags_asserts.sv
`timescale 1ns/1ps
module can_fifo_status_flags_chk (
  // Watched ports.
  input wire logic       clk_sys, rstn, fifo_direction_select, msg_done, fifo_reset, transmit_queue_reset,
  input wire logic       sticky_event, status_read, send_request_bit, serial_write, sticky_status,
  input wire logic       empty_or_full_flag, half_level_flag, not_full_or_not_empty_flag,
  input wire logic [4:0] fifo_depth_setting, current_message_index,
  input wire logic [5:0] message_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Short names; n counts slots, one more than the setting.
  wire t = fifo_direction_select, e = empty_or_full_flag, h = half_level_flag, f = not_full_or_not_empty_flag;
  wire [5:0] c = message_count, n = fifo_depth_setting + 6'h01;
  wire [4:0] x = current_message_index;
  wire k = fifo_reset | transmit_queue_reset;
  ef_tx_a: assert property (t |-> e == (c == 6'h00)) else $error("empty");
  ef_rx_a: assert property (!t |-> e == (c == n)) else $error("full");
  half_tx_a: assert property (t |-> h == (2 * c <= n)) else $error("half tx");
  half_rx_a: assert property (!t |-> h == (2 * c >= n)) else $error("half rx");
  low_tx_a: assert property (t |-> f == (c < n)) else $error("not full");
  low_rx_a: assert property (!t |-> f == (c != 6'h00)) else $error("not empty");
  idx_step_a: assert property (msg_done && c != 6'h00 && !k |=>
    x == (($past(x) == $past(fifo_depth_setting)) ? 5'h00 : $past(x) + 5'h01)) else $error("index step");
  idx_hold_a: assert property (!msg_done && !k |=> $stable(x)) else $error("index held");
  // A set in the clearing cycle must win, so the clear is only checked without one.
  sticky_set_a: assert property (sticky_event |=> sticky_status) else $error("sticky set");
  sticky_clear_a: assert property (!sticky_event && (status_read || transmit_queue_reset ||
    send_request_bit || serial_write) |=> !sticky_status) else $error("sticky clear");
  // Reaching full and wrapping the index are the cases worth seeing.
  cover property (t && c == n);
  cover property (!t && c == n);
  cover property (msg_done && x == fifo_depth_setting);
endmodule
bind can_fifo_status_flags can_fifo_status_flags_chk chk (.*);

// ### sim/can_fifo_status_flags_tb.sv
`timescale 1ns/1ps
module can_fifo_status_flags_tb;
  logic clk_sys = 0, rstn = 0, fifo_direction_select = 0, fifo_reset = 0, transmit_queue_reset = 0;
  logic send_request_bit = 0, serial_write = 0, sticky_event = 0, status_read = 0;
  logic [4:0] fifo_depth_setting = 5'h03, current_message_index;
  logic [5:0] message_count;
  logic msg_queued, msg_done, empty_or_full_flag, half_level_flag, not_full_or_not_empty_flag, sticky_status;
  int num_errors = 0, check_count = 0, n, c, i;
  // The clock runs at 100 ns.
  always #50 clk_sys = ~clk_sys;
  can_msg_engine eng (.*);
  can_fifo_status_flags dut (.*);
  task automatic tick;
    @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input string s, input logic [5:0] e, input logic [5:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Flags must follow the count in the same cycle, read per direction.
  task automatic look;
    chk("count", c[5:0], message_count);
    chk("index", i[5:0], {1'b0, current_message_index});
    chk("flags", fifo_direction_select ? {c == 0, 2 * c <= n, c < n} : {c == n, 2 * c >= n, c != 0},
        {empty_or_full_flag, half_level_flag, not_full_or_not_empty_flag});
  endtask
  // Fill past full, then drain, both directions, odd and even slot counts.
  initial begin
    repeat (5) @(posedge clk_sys);
    #10 rstn = 1;
    for (int m = 0; m < 4; m++) begin
      {fifo_depth_setting[0], fifo_direction_select} = m[1:0];
      n = fifo_depth_setting + 1;
      fifo_reset = 1;
      tick;
      fifo_reset = 0;
      c = 0;
      i = 0;
      eng.set(1, 0);
      repeat (n + 1) begin
        tick;
        c += c < n;
        look;
      end
      eng.set(0, 1);
      repeat (n) begin
        tick;
        c--;
        i = (i + 1) % n;
        look;
      end
      // A done on an empty FIFO and a queue beside a done both leave the count.
      tick;
      i = (i + 1) % n;
      look;
      eng.set(1, 0);
      tick;
      c = 1;
      look;
      eng.set(1, 1);
      tick;
      i = (i + 1) % n;
      look;
      eng.set(0, 0);
    end
    for (int k = 0; k < 4; k++) begin
      sticky_event = 1;
      tick;
      sticky_event = 0;
      chk("sticky set", 6'h01, {5'h00, sticky_status});
      {status_read, transmit_queue_reset, send_request_bit, serial_write} = 4'h8 >> k;
      tick;
      {status_read, transmit_queue_reset, send_request_bit, serial_write} = 4'h0;
      chk("sticky clear", 6'h00, {5'h00, sticky_status});
    end
    // An event in the same cycle as a status read must not be lost.
    sticky_event = 1;
    status_read = 1;
    tick;
    {sticky_event, status_read} = 2'h0;
    chk("sticky set wins", 6'h01, {5'h00, sticky_status});
    wrap_up;
  end
  // About sixty cycles are needed; a hang is cut well after that.
  initial begin
    #200000;
    num_errors++;
    wrap_up;
  end
endmodule

// ### sim/can_msg_engine.sv
`timescale 1ns/1ps
// Engine side: strobes are levels, so each edge they are held counts one event.
module can_msg_engine (
  output logic msg_queued,
  output logic msg_done
);
  initial {msg_queued, msg_done} = 2'h0;
  // Callers move the levels just after an edge only.
  task automatic set(input logic q, input logic d);
    {msg_queued, msg_done} = {q, d};
  endtask
endmodule
